// file: ppr_receive_port.sv
// Overview of operation
// - host frames bytes with idle-high strobe; data taken while strobe low
// - data lines carry bits one to eight, high means one
// - after a byte is taken and room exists, pulse accept low ~5 us
// - busy high whenever a byte cannot be accepted, low otherwise
// - busy high in data entry, printing, offline and error
// - paper_out high whenever paper is exhausted
// - online_indicator high while the printer is selected and online
// - auto linefeed low requests a line advance after each line
// - switch 2-3 on forces auto linefeed low internally
// - init low resets controller state and discards the buffer
// - transfers paced by host strobes; flow by acknowledge or busy
// - switch 1-8 on forces select request asserted
// - switch 2-4 selects a one inch skip over perforation
// - form length 12 or 11 inches; spacing 1/8 or 1/6 inch
// - switches choose CR, buffer-full, cancel, buzzer, character set
// - data accepted only while selected, by pin or by switch
// - fault output low in paper end, offline or error
//
// The APB interface to the registers and the register offsets were decided locally.
module ppr_receive_port (
  input wire logic clock,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ppr_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] data_in,
  input wire logic data_strobe_n,
  input wire logic init_n,
  input wire logic auto_linefeed_n,
  input wire logic select_request_n,
  output logic busy,
  output logic accept_pulse_n,
  output logic paper_out,
  output logic online_indicator,
  output logic fault_n,
  output logic line_advance_req
);

  // ==========================================================================
  // helpers
  // ==========================================================================
  function automatic logic reg_hit(
    input logic [ppr_pkg::ADDR_W-1:0] addr,
    input logic [ppr_pkg::ADDR_W-1:0] offset
  );
    reg_hit = (addr == offset);
  endfunction

  function automatic logic [ppr_pkg::LINES_W-1:0] lines_per_page(
    input logic form_12in,
    input logic spacing_8lpi
  );
    logic [ppr_pkg::LINES_W-1:0] inches;
    logic [ppr_pkg::LINES_W-1:0] lpi;
    inches = form_12in ? ppr_pkg::FORM_12IN : ppr_pkg::FORM_11IN;
    lpi = spacing_8lpi ? ppr_pkg::LINES_W'(ppr_pkg::LPI_8)
                       : ppr_pkg::LINES_W'(ppr_pkg::LPI_6);
    lines_per_page = ppr_pkg::LINES_W'(inches * lpi);
  endfunction

  // ==========================================================================
  // pin synchronisers
  // ==========================================================================
  logic [ppr_pkg::PIN_W-1:0] pins_sync;
  logic [7:0] data_sync;
  logic strobe_n_sync;
  logic init_n_sync;
  logic autofeed_n_sync;
  logic select_n_sync;

  // control lines reset to their idle levels so reset looks like idle
  ppr_sync #(
    .WIDTH(ppr_pkg::PIN_W)
  ) u_pin_sync (
    .clock(clock),
    .srst(srst),
    .async_in({data_in, data_strobe_n, init_n, auto_linefeed_n,
               select_request_n}),
    .reset_level({8'h00, 4'hF}),
    .sync_out(pins_sync)
  );

  assign data_sync = pins_sync[11:4];
  assign strobe_n_sync = pins_sync[3];
  assign init_n_sync = pins_sync[2];
  assign autofeed_n_sync = pins_sync[1];
  assign select_n_sync = pins_sync[0];

  // ==========================================================================
  // state
  // ==========================================================================
  typedef enum logic [1:0] {
    RX_IDLE,
    RX_ENTRY,
    RX_WAIT_HIGH
  } ppr_rx_mode_type;

  typedef struct packed {
    ppr_rx_mode_type rx_mode;
    logic [ppr_pkg::STRB_CNT_W-1:0] strb_cnt;
    logic [7:0] rx_byte;
    logic byte_held;
    logic [ppr_pkg::CTRL_W-1:0] ctrl;
    logic [ppr_pkg::SW_W-1:0] sw;
    logic init_seen;
    logic overrun;
    logic busy;
    logic ack_n;
    logic paper_out;
    logic online;
    logic fault_n;
    logic line_adv;
    logic [31:0] prdata;
  } ppr_port_state_type;

  localparam ppr_port_state_type STATE_RESET = '{
    rx_mode: RX_IDLE,
    strb_cnt: '0,
    rx_byte: 8'h00,
    byte_held: 1'b0,
    ctrl: ppr_pkg::CTRL_RESET,
    sw: ppr_pkg::SW_RESET,
    init_seen: 1'b0,
    overrun: 1'b0,
    busy: 1'b1,
    ack_n: 1'b1,
    paper_out: 1'b0,
    online: 1'b0,
    fault_n: 1'b1,
    line_adv: 1'b0,
    prdata: 32'h0000_0000
  };

  ppr_port_state_type state_q;
  ppr_port_state_type state_d;

  logic ack_active;
  logic ack_start;
  logic init_active;

  // ==========================================================================
  // acknowledge one-shot
  // ==========================================================================
  ppr_pulse_timer u_ack_timer (
    .clock(clock),
    .srst(srst),
    .start(ack_start),
    .abort(init_active),
    .active(ack_active)
  );

  // ==========================================================================
  // next-state logic
  // ==========================================================================
  logic wr_access;
  logic rd_setup;
  logic rd_access;
  logic mapped;
  logic selected;
  logic ready_for_byte;
  logic pop;
  logic w1c_init;
  logic w1c_overrun;
  logic capture;
  logic refuse;
  logic [31:0] rd_word;
  logic [31:0] status_word;
  logic [31:0] format_word;

  always_comb
  begin
    state_d = state_q;
    wr_access = psel && penable && pwrite;
    rd_setup = psel && !penable && !pwrite;
    rd_access = psel && penable && !pwrite;
    mapped = reg_hit(paddr, ppr_pkg::REG_CTRL)
          || reg_hit(paddr, ppr_pkg::REG_SWITCH)
          || reg_hit(paddr, ppr_pkg::REG_STATUS)
          || reg_hit(paddr, ppr_pkg::REG_DATA)
          || reg_hit(paddr, ppr_pkg::REG_FORMAT);
    init_active = !init_n_sync;
    selected = state_q.sw[ppr_pkg::SW_SELECT_FIXED] || !select_n_sync;
    // every reason the printer cannot take a byte right now
    ready_for_byte = selected
                  && state_q.ctrl[ppr_pkg::CTRL_ONLINE]
                  && !state_q.ctrl[ppr_pkg::CTRL_PAPER_EMPTY]
                  && !state_q.ctrl[ppr_pkg::CTRL_MECH_ERROR]
                  && !state_q.ctrl[ppr_pkg::CTRL_PRINTING]
                  && !state_q.byte_held
                  && !ack_active
                  && !init_active;
    pop = rd_access && reg_hit(paddr, ppr_pkg::REG_DATA)
       && state_q.byte_held;
    // room is back once software has taken the byte
    ack_start = pop && !init_active;
    w1c_init = wr_access && reg_hit(paddr, ppr_pkg::REG_STATUS)
            && pwdata[ppr_pkg::ST_INIT_SEEN];
    w1c_overrun = wr_access && reg_hit(paddr, ppr_pkg::REG_STATUS)
               && pwdata[ppr_pkg::ST_OVERRUN];
    capture = 1'b0;
    refuse = 1'b0;

    // strobe qualification: a byte counts only after the minimum low time
    case (state_q.rx_mode)
      RX_IDLE:
      begin
        state_d.strb_cnt = '0;
        if (!strobe_n_sync)
        begin
          state_d.rx_mode = RX_ENTRY;
        end
      end
      RX_ENTRY:
      begin
        if (strobe_n_sync)
        begin
          // short glitch: no byte, no acknowledge
          state_d.rx_mode = RX_IDLE;
        end
        else if (state_q.strb_cnt
                 == ppr_pkg::STRB_CNT_W'(ppr_pkg::STROBE_MIN_CYC - 2))
        begin
          capture = ready_for_byte;
          refuse = !ready_for_byte;
          state_d.rx_mode = RX_WAIT_HIGH;
        end
        else
        begin
          state_d.strb_cnt = state_q.strb_cnt + 1'b1;
        end
      end
      RX_WAIT_HIGH:
      begin
        // one byte per strobe, however long it stays low
        if (strobe_n_sync)
        begin
          state_d.rx_mode = RX_IDLE;
        end
      end
      default:
      begin
        state_d.rx_mode = RX_IDLE;
      end
    endcase

    if (capture)
    begin
      state_d.rx_byte = data_sync;
      state_d.byte_held = 1'b1;
    end
    else if (pop)
    begin
      state_d.byte_held = 1'b0;
    end

    // software side: controls and switch bank
    if (wr_access && reg_hit(paddr, ppr_pkg::REG_CTRL))
    begin
      state_d.ctrl = pwdata[ppr_pkg::CTRL_W-1:0];
    end
    if (wr_access && reg_hit(paddr, ppr_pkg::REG_SWITCH))
    begin
      state_d.sw = pwdata[ppr_pkg::SW_W-1:0];
    end

    // sticky flags: a new event wins over a clear in the same cycle
    state_d.overrun = (state_q.overrun && !w1c_overrun) || refuse;
    state_d.init_seen = (state_q.init_seen && !w1c_init) || init_active;

    if (init_active)
    begin
      // drop any held byte and any half-taken strobe
      state_d.byte_held = 1'b0;
      state_d.rx_byte = 8'h00;
      state_d.rx_mode = strobe_n_sync ? RX_IDLE : RX_WAIT_HIGH;
      state_d.strb_cnt = '0;
    end

    // pin outputs, all registered
    state_d.busy = !ready_for_byte
                || state_d.rx_mode != RX_IDLE
                || capture;
    state_d.ack_n = !ack_active;
    state_d.paper_out = state_q.ctrl[ppr_pkg::CTRL_PAPER_EMPTY];
    state_d.online = selected && state_q.ctrl[ppr_pkg::CTRL_ONLINE];
    state_d.fault_n = !(state_q.ctrl[ppr_pkg::CTRL_PAPER_EMPTY]
                     || !state_q.ctrl[ppr_pkg::CTRL_ONLINE]
                     || state_q.ctrl[ppr_pkg::CTRL_MECH_ERROR]);
    state_d.line_adv = !autofeed_n_sync
                    || state_q.sw[ppr_pkg::SW_AUTOFEED_FIXED];

    // read words
    status_word = 32'h0000_0000;
    status_word[ppr_pkg::ST_BYTE_READY] = state_q.byte_held;
    status_word[ppr_pkg::ST_BUSY] = state_q.busy;
    status_word[ppr_pkg::ST_ACK] = ack_active;
    status_word[ppr_pkg::ST_SELECTED] = selected;
    status_word[ppr_pkg::ST_AUTOFEED] = state_q.line_adv;
    status_word[ppr_pkg::ST_INIT_SEEN] = state_q.init_seen;
    status_word[ppr_pkg::ST_OVERRUN] = state_q.overrun;

    format_word = 32'h0000_0000;
    format_word[ppr_pkg::FMT_LINES_LSB +: ppr_pkg::LINES_W] =
      lines_per_page(state_q.sw[ppr_pkg::SW_FORM_12IN],
                     state_q.sw[ppr_pkg::SW_SPACING_8LPI]);
    if (state_q.sw[ppr_pkg::SW_PERF_SKIP])
    begin
      format_word[ppr_pkg::FMT_SKIP_LSB +: ppr_pkg::SKIP_W] =
        state_q.sw[ppr_pkg::SW_SPACING_8LPI] ? ppr_pkg::LPI_8
                                             : ppr_pkg::LPI_6;
    end
    format_word[ppr_pkg::FMT_CR_LF] =
      !state_q.sw[ppr_pkg::SW_CR_PRINT_ONLY];
    format_word[ppr_pkg::FMT_FULL_LF] =
      !state_q.sw[ppr_pkg::SW_FULL_PRINT_ONLY];
    format_word[ppr_pkg::FMT_CANCEL_OK] =
      !state_q.sw[ppr_pkg::SW_CANCEL_INVALID];
    format_word[ppr_pkg::FMT_DELETE_OK] =
      !state_q.sw[ppr_pkg::SW_DELETE_INVALID];
    format_word[ppr_pkg::FMT_BUZZER] = state_q.sw[ppr_pkg::SW_BUZZER];
    format_word[ppr_pkg::FMT_CHARSET2] = state_q.sw[ppr_pkg::SW_CHARSET2];

    rd_word = 32'h0000_0000;
    if (reg_hit(paddr, ppr_pkg::REG_CTRL))
    begin
      rd_word[ppr_pkg::CTRL_W-1:0] = state_q.ctrl;
    end
    else if (reg_hit(paddr, ppr_pkg::REG_SWITCH))
    begin
      rd_word[ppr_pkg::SW_W-1:0] = state_q.sw;
    end
    else if (reg_hit(paddr, ppr_pkg::REG_STATUS))
    begin
      rd_word = status_word;
    end
    else if (reg_hit(paddr, ppr_pkg::REG_DATA))
    begin
      rd_word[7:0] = state_q.rx_byte;
    end
    else if (reg_hit(paddr, ppr_pkg::REG_FORMAT))
    begin
      rd_word = format_word;
    end

    // read data is latched in the setup cycle so it comes from a flop
    if (rd_setup)
    begin
      state_d.prdata = rd_word;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state_q <= STATE_RESET;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  // zero wait states; unmapped offsets answer with an error and zero data
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = state_q.prdata;
  assign busy = state_q.busy;
  assign accept_pulse_n = state_q.ack_n;
  assign paper_out = state_q.paper_out;
  assign online_indicator = state_q.online;
  assign fault_n = state_q.fault_n;
  assign line_advance_req = state_q.line_adv;

endmodule

// file: ppr_pkg.sv
package ppr_pkg;

  // ==========================================================================
  // clock and link timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 40;
  localparam int STROBE_MIN_NS = 500;
  localparam int ACK_PULSE_NS = 5000;
  // least time rounds up, nominal pulse rounds down
  localparam int STROBE_MIN_CYC =
    (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACK_PULSE_CYC = ACK_PULSE_NS / CLK_PERIOD_NS;
  localparam int STRB_CNT_W = 4;
  localparam int ACK_CNT_W = 8;

  // ==========================================================================
  // register bus
  // ==========================================================================
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_SWITCH = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] REG_DATA = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_FORMAT = 8'h10;

  // control register fields
  localparam int CTRL_W = 4;
  localparam int CTRL_ONLINE = 0;
  localparam int CTRL_PAPER_EMPTY = 1;
  localparam int CTRL_MECH_ERROR = 2;
  localparam int CTRL_PRINTING = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h1;

  // switch register: bits 0..7 are bank 1 switches 1..8, 8..11 bank 2
  localparam int SW_W = 12;
  localparam int SW_CR_PRINT_ONLY = 1;
  localparam int SW_FULL_PRINT_ONLY = 2;
  localparam int SW_CANCEL_INVALID = 3;
  localparam int SW_DELETE_INVALID = 4;
  localparam int SW_BUZZER = 5;
  localparam int SW_CHARSET2 = 6;
  localparam int SW_SELECT_FIXED = 7;
  localparam int SW_FORM_12IN = 8;
  localparam int SW_SPACING_8LPI = 9;
  localparam int SW_AUTOFEED_FIXED = 10;
  localparam int SW_PERF_SKIP = 11;
  localparam logic [SW_W-1:0] SW_RESET = 12'h0B3;

  // status register fields
  localparam int ST_BYTE_READY = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_ACK = 2;
  localparam int ST_SELECTED = 3;
  localparam int ST_AUTOFEED = 4;
  localparam int ST_INIT_SEEN = 5;
  localparam int ST_OVERRUN = 6;

  // format register fields
  localparam int FMT_LINES_LSB = 0;
  localparam int FMT_SKIP_LSB = 8;
  localparam int FMT_CR_LF = 16;
  localparam int FMT_FULL_LF = 17;
  localparam int FMT_CANCEL_OK = 18;
  localparam int FMT_DELETE_OK = 19;
  localparam int FMT_BUZZER = 20;
  localparam int FMT_CHARSET2 = 21;

  // ==========================================================================
  // page geometry
  // ==========================================================================
  localparam int LINES_W = 7;
  localparam int SKIP_W = 4;
  localparam logic [LINES_W-1:0] FORM_11IN = 7'h0B;
  localparam logic [LINES_W-1:0] FORM_12IN = 7'h0C;
  localparam logic [SKIP_W-1:0] LPI_6 = 4'h6;
  localparam logic [SKIP_W-1:0] LPI_8 = 4'h8;

  // pin inputs passed through the synchroniser, packed in this order
  localparam int PIN_W = 12;

endpackage

// file: ppr_sync.sv
module ppr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async_in,
  input wire logic [WIDTH-1:0] reset_level,
  output logic [WIDTH-1:0] sync_out
);

  // ==========================================================================
  // two-stage synchroniser; only the second stage leaves this module
  // ==========================================================================
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } ppr_sync_state_type;

  ppr_sync_state_type state_q;
  ppr_sync_state_type state_d;

  always_comb
  begin
    state_d = state_q;
    state_d.meta = async_in;
    state_d.stable = state_q.meta;
  end

  // reset level is a tie-off constant so idle lines do not look active
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state_q.meta <= reset_level;
      state_q.stable <= reset_level;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign sync_out = state_q.stable;

endmodule

// file: ppr_pulse_timer.sv
module ppr_pulse_timer (
  input wire logic clock,
  input wire logic srst,
  input wire logic start,
  input wire logic abort,
  output logic active
);

  // ==========================================================================
  // one-shot of fixed length, restartable only once it has ended
  // ==========================================================================
  typedef struct packed {
    logic [ppr_pkg::ACK_CNT_W-1:0] count;
    logic active;
  } ppr_timer_state_type;

  ppr_timer_state_type state_q;
  ppr_timer_state_type state_d;

  always_comb
  begin
    state_d = state_q;
    if (abort)
    begin
      state_d.active = 1'b0;
      state_d.count = '0;
    end
    else if (state_q.active)
    begin
      if (state_q.count == ppr_pkg::ACK_CNT_W'(ppr_pkg::ACK_PULSE_CYC - 1))
      begin
        state_d.active = 1'b0;
        state_d.count = '0;
      end
      else
      begin
        state_d.count = state_q.count + 1'b1;
      end
    end
    else if (start)
    begin
      state_d.active = 1'b1;
      state_d.count = '0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign active = state_q.active;

endmodule

// file: ppr_receive_port_checker.sv
module ppr_receive_port_checker (
  input wire logic clock,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ppr_pkg::ADDR_W-1:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic data_strobe_n,
  input wire logic init_n,
  input wire logic auto_linefeed_n,
  input wire logic busy,
  input wire logic accept_pulse_n,
  input wire logic paper_out,
  input wire logic fault_n,
  input wire logic line_advance_req
);
  // ==========================================================================
  // helper: length of the current acknowledge pulse
  // ==========================================================================
  int ack_cnt_q;
  always_ff @(posedge clock)
  begin
    if (srst || accept_pulse_n)
      ack_cnt_q <= 0;
    else
      ack_cnt_q <= ack_cnt_q + 1;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_strobe_fall;
    $fell(data_strobe_n);
  endsequence
  sequence s_init_hold;
    !init_n [*5];
  endsequence
  sequence s_feed_low;
    !auto_linefeed_n [*4];
  endsequence

  // ==========================================================================
  // assertions
  // ==========================================================================
  a_ack_width_max: assert property (!accept_pulse_n |->
    ack_cnt_q < ppr_pkg::ACK_PULSE_CYC) else $error("ack pulse too long");
  // an init abort may cut the pulse short, so only whole pulses are timed
  a_ack_width_full: assert property ($rose(accept_pulse_n) &&
    $past(init_n, 2) && $past(init_n, 3) && $past(init_n, 4) &&
    $past(init_n, 5) |-> ack_cnt_q == ppr_pkg::ACK_PULSE_CYC)
    else $error("ack pulse too short");
  a_ack_after_read: assert property ($fell(accept_pulse_n) |->
    $past(psel && penable && !pwrite && paddr == ppr_pkg::REG_DATA, 2))
    else $error("ack pulse without data read");
  a_busy_in_ack: assert property (!accept_pulse_n |-> busy)
    else $error("busy low during ack");
  a_entry_busy: assert property (s_strobe_fall |-> ##[1:4] busy)
    else $error("busy not raised on strobe");
  a_init_clears: assert property (s_init_hold |->
    busy && accept_pulse_n) else $error("init did not reset port");
  a_feed_pin: assert property (s_feed_low |-> line_advance_req)
    else $error("auto linefeed not followed");
  a_paper_fault: assert property (paper_out |-> !fault_n && busy)
    else $error("paper out without fault and busy");
  a_ready_tied: assert property (psel && penable |-> pready)
    else $error("apb wait state");
  a_err_phase: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
endmodule

bind ppr_receive_port ppr_receive_port_checker u_ppr_receive_port_checker (
  .clock, .srst, .psel, .penable, .pwrite, .paddr, .pready, .pslverr,
  .data_strobe_n, .init_n, .auto_linefeed_n, .busy, .accept_pulse_n,
  .paper_out, .fault_n, .line_advance_req
);

// file: ppr_host_model.sv
module ppr_host_model #(
  parameter int MIN_GAP_CYC = 25000,
  parameter int INIT_CYC = 1251
) (
  input wire logic clock,
  output logic [7:0] data_in,
  output logic data_strobe_n,
  output logic init_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int cyc_q = 0;
  int last_q = -MIN_GAP_CYC;

  initial
  begin
    data_in = 8'h00;
    data_strobe_n = 1'b1;
    init_n = 1'b1;
  end

  always @(posedge clock)
    cyc_q <= cyc_q + 1;

  // ==========================================================================
  // one byte per strobe; width below 13 cycles only when a test asks
  // ==========================================================================
  task automatic send_byte(input logic [7:0] b, input int width);
    while (cyc_q - last_q < MIN_GAP_CYC)
      @(posedge clock);
    @(posedge clock);
    data_in <= b;
    @(posedge clock);
    last_q = cyc_q;
    data_strobe_n <= 1'b0;
    repeat (width) @(posedge clock);
    data_strobe_n <= 1'b1;
    repeat (2) @(posedge clock);
    // hold time over: lines no longer show the byte
    data_in <= ~b;
  endtask

  task automatic init_pulse();
    @(posedge clock);
    init_n <= 1'b0;
    repeat (INIT_CYC) @(posedge clock);
    init_n <= 1'b1;
  endtask
endmodule

// file: ppr_receive_port_test.sv
module ppr_receive_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, err_q;
  logic [7:0] data_in;
  logic data_strobe_n, init_n;
  logic auto_linefeed_n = 1'b1;
  logic select_request_n = 1'b1;
  logic busy, accept_pulse_n, paper_out, online_indicator, fault_n;
  logic line_advance_req;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;

  ppr_receive_port u_ppr_receive_port (.clock, .srst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .data_in,
    .data_strobe_n, .init_n, .auto_linefeed_n, .select_request_n, .busy,
    .accept_pulse_n, .paper_out, .online_indicator, .fault_n,
    .line_advance_req);
  // short byte gap keeps the run brief
  ppr_host_model #(.MIN_GAP_CYC(400)) u_ppr_host_model (.clock, .data_in,
    .data_strobe_n, .init_n);

  initial
  begin
    forever #20 clock = ~clock;
  end

  // ==========================================================================
  // shared tasks
  // ==========================================================================
  task automatic test_done();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_fail++;
      test_done();
    end
  end

  task automatic check(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
      @(posedge clock);
    while (pready !== 1'b1);
    r = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // counts edges while the chosen output keeps the given level
  task automatic hold(input bit ack, input logic lvl, input int lim,
    output int n);
    n = 0;
    while ((ack ? accept_pulse_n : busy) === lvl && n < lim)
    begin
      @(posedge clock);
      n++;
    end
  endtask

  task automatic poll_ready(output logic [31:0] r);
    int n = 0;
    do
    begin
      apb(1'b0, ppr_pkg::REG_STATUS, 32'h0, r);
      n++;
    end
    while (r[0] !== 1'b1 && n < 20);
  endtask

  function automatic logic [31:0] fmt_exp(input logic [11:0] sw);
    logic [31:0] f;
    logic [3:0] lpi;
    lpi = sw[9] ? 4'h8 : 4'h6;
    f = 32'h0;
    f[6:0] = (sw[8] ? 7'h0C : 7'h0B) * lpi;
    f[11:8] = sw[11] ? lpi : 4'h0;
    f[21:16] = {sw[6], sw[5], ~sw[4:1]};
    return f;
  endfunction

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial
  begin
    logic [31:0] r;
    logic [7:0] b;
    logic [11:0] sw;
    logic [3:0] v;
    int k, n;
    r = $urandom(32'hFB4DB2D4);
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    apb(1'b0, ppr_pkg::REG_CTRL, 32'h0, r);
    check("ctrl reset", r, 32'h1);
    apb(1'b0, ppr_pkg::REG_SWITCH, 32'h0, r);
    check("switch reset", r, 32'h0B3);
    apb(1'b1, ppr_pkg::REG_FORMAT, 32'hFFFFFFFF, r);
    apb(1'b0, ppr_pkg::REG_FORMAT, 32'h0, r);
    check("format reset", r, fmt_exp(12'h0B3));
    apb(1'b1, 8'h14, 32'hFFFFFFFF, r);
    check("unmapped write", err_q, 32'h1);
    apb(1'b0, 8'h14, 32'h0, r);
    check("unmapped read", {r[30:0], err_q}, 32'h1);
    // bytes from the shortest legal strobe upward, the first two with single bits set
    for (k = 0; k < 4; k++)
    begin
      b = (k == 0) ? 8'h01 : (k == 1) ? 8'h80 : 8'($urandom);
      hold(1'b0, 1'b1, 400, n);
      u_ppr_host_model.send_byte(b, 13 + k * 7);
      poll_ready(r);
      check("byte ready", r[0], 32'h1);
      check("busy while held", busy, 32'h1);
      apb(1'b0, ppr_pkg::REG_DATA, 32'h0, r);
      check("byte", r, {24'h0, b});
      hold(1'b1, 1'b1, 10, n);
      hold(1'b1, 1'b0, 300, n);
      check("ack length", 32'(n), 32'(ppr_pkg::ACK_PULSE_CYC));
      hold(1'b0, 1'b1, 4, n);
      check("busy after ack", busy, 32'h0);
    end
    u_ppr_host_model.send_byte(8'hA5, 8);
    repeat (20) @(posedge clock);
    apb(1'b0, ppr_pkg::REG_STATUS, 32'h0, r);
    check("short strobe", {r[6], r[0]}, 32'h0);
    // a held byte is thrown away by init
    u_ppr_host_model.send_byte(8'h3C, 20);
    u_ppr_host_model.init_pulse();
    apb(1'b0, ppr_pkg::REG_STATUS, 32'h0, r);
    check("init clears", {r[5], r[0]}, 32'h2);
    for (k = 0; k < 5; k++)
    begin
      v = 4'(20'h19530 >> (4 * k));
      apb(1'b1, ppr_pkg::REG_CTRL, {28'h0, v}, r);
      repeat (4) @(posedge clock);
      check("paper out", paper_out, v[1]);
      check("fault", fault_n, v[0] & ~v[1] & ~v[2]);
      check("online", online_indicator, v[0]);
      check("busy state", busy, v != 4'h1);
    end
    // offline: the byte is refused and flagged
    apb(1'b1, ppr_pkg::REG_CTRL, 32'h0, r);
    u_ppr_host_model.send_byte(8'h5A, 20);
    apb(1'b0, ppr_pkg::REG_STATUS, 32'h0, r);
    check("refused offline", {r[6], r[0]}, 32'h2);
    apb(1'b1, ppr_pkg::REG_STATUS, 32'h40, r);
    apb(1'b0, ppr_pkg::REG_STATUS, 32'h0, r);
    check("overrun cleared", r[6], 32'h0);
    apb(1'b1, ppr_pkg::REG_CTRL, 32'h1, r);
    apb(1'b1, ppr_pkg::REG_SWITCH, 32'h033, r);
    repeat (5) @(posedge clock);
    check("pin deselects", online_indicator, 32'h0);
    select_request_n <= 1'b0;
    repeat (5) @(posedge clock);
    check("pin selects", online_indicator, 32'h1);
    auto_linefeed_n <= 1'b0;
    repeat (5) @(posedge clock);
    check("feed pin", line_advance_req, 32'h1);
    auto_linefeed_n <= 1'b1;
    repeat (5) @(posedge clock);
    check("feed off", line_advance_req, 32'h0);
    apb(1'b1, ppr_pkg::REG_SWITCH, 32'h4B3, r);
    repeat (3) @(posedge clock);
    check("feed fixed", line_advance_req, 32'h1);
    for (k = 0; k < 6; k++)
    begin
      sw = 12'($urandom);
      apb(1'b1, ppr_pkg::REG_SWITCH, {20'h0, sw}, r);
      apb(1'b0, ppr_pkg::REG_SWITCH, 32'h0, r);
      check("switch", r, {20'h0, sw});
      apb(1'b0, ppr_pkg::REG_FORMAT, 32'h0, r);
      check("format", r, fmt_exp(sw));
    end
    test_done();
  end
endmodule
